//--- src/wdt_pkg.sv
// Package: constants and carriers for the watchdog with stop-mode control.
// Assumes a single 20 MHz system clock and a synchronous active-high reset.
package wdt_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned LOW_WIDTH       = 8;
  localparam int unsigned HIGH_WIDTH      = 8;
  localparam logic [7:0]  LOW_INIT        = 8'hFF;
  localparam logic [7:0]  HIGH_INIT       = 8'hFF;
  localparam int unsigned STAB_COUNTS     = 512;
  localparam int unsigned STAB_WIDTH      = 10;
  localparam int unsigned SERVICE_MAX_US  = 65536;
  localparam int unsigned CTRL_SEL_BIT    = 7;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    RUN,
    STOPPED,
    STABILIZE
  } pwr_state_e;

  typedef struct packed {
    logic       wr;
    logic [7:0] data;
  } ctrl_wr_s;

  typedef struct packed {
    logic core_halt;
    logic periph_halt;
    logic osc_stop;
    logic clk_hold_high;
  } pwr_ctl_s;

endpackage : wdt_pkg

//--- src/wdt_stage.sv
// Module: one reloadable down-counting watchdog stage.
// Assumes tick comes from logic on the same clock.
`timescale 1ns/100ps
module wdt_stage #(
  parameter int unsigned     WIDTH = 8,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic reload,
  input  wire logic tick,
  output logic      underflow
);

  logic [WIDTH-1:0] count_ff;
  logic [WIDTH-1:0] nxt_count;
  logic             nxt_underflow;
  logic             underflow_ff;

  // ****************************************
  // Counter
  // ****************************************
  always_comb begin
    nxt_count     = count_ff;
    nxt_underflow = 1'b0;
    if (reload) begin
      nxt_count = INIT;
    end else if (tick) begin
      if (count_ff == '0) begin
        nxt_count     = INIT;
        nxt_underflow = 1'b1;
      end else begin
        nxt_count = count_ff - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      count_ff     <= INIT;
      underflow_ff <= 1'b0;
    end else begin
      count_ff     <= nxt_count;
      underflow_ff <= nxt_underflow;
    end
  end

  assign underflow = underflow_ff;

endmodule : wdt_stage

//--- src/wdt_stop.sv
// Module: two-stage watchdog, stop-instruction control and stop release.
// Assumes the core reports control writes and stop execution as one-cycle
// pulses on clk; wake interrupt arrives already enabled and synchronised.
`timescale 1ns/100ps

// Notes on behaviour
// - With control bit 7 clear the high stage counts each low-stage underflow.
// - A high-stage underflow raises the chip reset output.
// - The watchdog keeps counting during the stabilisation wait after stop release.
// - Once set, the stop-disable bit cannot be cleared by software until reset.
// - Executing stop halts both oscillators and holds the internal clock high.
// - In stop mode the core halts and peripherals are suspended.
// - Stop mode ends on reset or on an enabled interrupt request.
// - With the stabilisation select bit clear, wait 512 source counts after release.
module wdt_stop (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire wdt_pkg::ctrl_wr_s ctrl_wr,
  input  wire logic              stop_disable_wr,
  input  wire logic              stop_disable_data,
  input  wire logic              stop_instruction,
  input  wire logic              wake_irq,
  input  wire logic              stab_sel,
  input  wire logic              count_src,
  output logic                   chip_reset,
  output logic                   stop_disabled,
  output wdt_pkg::pwr_ctl_s      pwr_ctl,
  output logic [7:0]             ctrl_value
);

  // ****************************************
  // State
  // ****************************************
  wdt_pkg::pwr_state_e                 state_ff;
  wdt_pkg::pwr_state_e                 nxt_state;
  logic [wdt_pkg::STAB_WIDTH-1:0]      stab_ff;
  logic [wdt_pkg::STAB_WIDTH-1:0]      nxt_stab;
  logic                                dis_ff;
  logic                                nxt_dis;
  logic [7:0]                          ctrl_ff;
  logic [7:0]                          nxt_ctrl;
  logic                                rst_ff;
  logic                                nxt_rst;
  logic                                low_uf;
  logic                                high_uf;
  logic                                high_tick;
  logic                                wdt_run;

  localparam logic [wdt_pkg::STAB_WIDTH-1:0] STAB_LAST =
    wdt_pkg::STAB_WIDTH'(wdt_pkg::STAB_COUNTS - 1);

  // ****************************************
  // Watchdog stages
  // ****************************************
  assign wdt_run   = (state_ff != wdt_pkg::STOPPED);
  assign high_tick = ctrl_ff[wdt_pkg::CTRL_SEL_BIT] ? (wdt_run & count_src)
                                                    : low_uf;

  wdt_stage #(
    .WIDTH (wdt_pkg::LOW_WIDTH),
    .INIT  (wdt_pkg::LOW_INIT)
  ) u_low (
    .clk       (clk),
    .reset     (reset),
    .reload    (ctrl_wr.wr),
    .tick      (wdt_run & count_src),
    .underflow (low_uf)
  );

  wdt_stage #(
    .WIDTH (wdt_pkg::HIGH_WIDTH),
    .INIT  (wdt_pkg::HIGH_INIT)
  ) u_high (
    .clk       (clk),
    .reset     (reset),
    .reload    (ctrl_wr.wr),
    .tick      (high_tick),
    .underflow (high_uf)
  );

  // ****************************************
  // Control and stop logic
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_stab  = stab_ff;
    nxt_ctrl  = ctrl_ff;
    nxt_dis   = dis_ff;
    nxt_rst   = high_uf;
    if (ctrl_wr.wr) begin
      nxt_ctrl = ctrl_wr.data;
    end
    if (stop_disable_wr) begin
      nxt_dis = dis_ff | stop_disable_data;
    end
    case (state_ff)
      wdt_pkg::RUN: begin
        if (stop_instruction && !dis_ff) begin
          nxt_state = wdt_pkg::STOPPED;
        end
      end
      wdt_pkg::STOPPED: begin
        if (wake_irq) begin
          nxt_state = wdt_pkg::STABILIZE;
          nxt_stab  = '0;
        end
      end
      wdt_pkg::STABILIZE: begin
        if (stab_sel) begin
          nxt_state = wdt_pkg::RUN;
        end else if (count_src) begin
          if (stab_ff == STAB_LAST) begin
            nxt_state = wdt_pkg::RUN;
          end else begin
            nxt_stab = stab_ff + 1'b1;
          end
        end
      end
      default: begin
        nxt_state = wdt_pkg::RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= wdt_pkg::RUN;
      stab_ff  <= '0;
      ctrl_ff  <= wdt_pkg::CTRL_RESET;
      dis_ff   <= 1'b0;
      rst_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      stab_ff  <= nxt_stab;
      ctrl_ff  <= nxt_ctrl;
      dis_ff   <= nxt_dis;
      rst_ff   <= nxt_rst;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign chip_reset            = rst_ff;
  assign stop_disabled         = dis_ff;
  assign ctrl_value            = ctrl_ff;
  assign pwr_ctl.osc_stop      = (state_ff == wdt_pkg::STOPPED);
  assign pwr_ctl.clk_hold_high = (state_ff != wdt_pkg::RUN);
  assign pwr_ctl.core_halt     = (state_ff != wdt_pkg::RUN);
  assign pwr_ctl.periph_halt   = (state_ff == wdt_pkg::STOPPED);

endmodule : wdt_stop

//--- tb/wdt_stop_properties.sv
// Checker: port assertions for the watchdog with stop control.
// Assumes a bind from the bench top file and one clock domain.
`timescale 1ns/100ps
module wdt_stop_properties (
  input wire logic              clk,
  input wire logic              reset,
  input wire wdt_pkg::ctrl_wr_s ctrl_wr,
  input wire logic              stop_disable_wr,
  input wire logic              stop_disable_data,
  input wire logic              stop_instruction,
  input wire logic              wake_irq,
  input wire logic              stab_sel,
  input wire logic              count_src,
  input wire logic              chip_reset,
  input wire logic              stop_disabled,
  input wire wdt_pkg::pwr_ctl_s pwr_ctl,
  input wire logic [7:0]        ctrl_value
);
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_stop_enter: assert property (
    stop_instruction && !stop_disabled && pwr_ctl == 4'h0 |=> pwr_ctl == 4'hF)
    else $error("stop entry wrong");
  a_halt_hold: assert property (
    pwr_ctl == 4'hF && !wake_irq |=> pwr_ctl == 4'hF) else $error("stop left early");
  a_wake_leave: assert property (
    pwr_ctl == 4'hF && wake_irq && !stab_sel |=> pwr_ctl == 4'h9) else $error("wake wrong");
  a_stab_wait: assert property (
    pwr_ctl == 4'h9 && !stab_sel && !count_src |=> pwr_ctl == 4'h9)
    else $error("wait ended early");
  a_wait_skip: assert property (
    pwr_ctl == 4'h9 && stab_sel |=> pwr_ctl == 4'h0) else $error("skip wait wrong");
  a_ctrl_write: assert property (
    ctrl_wr.wr |=> ctrl_value == $past(ctrl_wr.data)) else $error("control write lost");
  a_reset_pulse: assert property (
    chip_reset |=> !chip_reset) else $error("chip reset too long");
  a_sticky_bit: assert property (
    stop_disabled |=> stop_disabled) else $error("stop disable cleared");
  a_bit_set: assert property (
    stop_disable_wr && stop_disable_data |=> stop_disabled) else $error("disable not set");
  a_stop_refused: assert property (
    stop_instruction && stop_disabled && pwr_ctl == 4'h0 |=> pwr_ctl == 4'h0)
    else $error("disabled stop taken");
endmodule : wdt_stop_properties

//--- tb/wdt_stop_bench.sv
// Bench: self-checking test of the watchdog with stop control.
// Assumes the package and design files are compiled first.
`timescale 1ns/100ps
module wdt_stop_bench;
  logic              clk = 0, reset = 1, stop_instruction = 0, wake_irq = 0, count_src = 0;
  logic              stop_disable_wr = 0, stop_disable_data = 0, stab_sel = 0, seen_rst = 0;
  logic              chip_reset, stop_disabled;
  logic [7:0]        ctrl_value;
  logic [3:0]        exp_q[$];
  logic [3:0]        last_pwr = '0;
  logic [31:0]       seed = 32'h7cfb_08c4;
  wdt_pkg::ctrl_wr_s ctrl_wr = '0;
  wdt_pkg::pwr_ctl_s pwr_ctl;
  int                n_fail = 0, tests_run = 0, n;
  always #25 clk = ~clk;
  wdt_stop dut (.clk(clk), .reset(reset), .ctrl_wr(ctrl_wr), .stop_disable_wr(stop_disable_wr),
    .stop_disable_data(stop_disable_data), .stop_instruction(stop_instruction),
    .wake_irq(wake_irq), .stab_sel(stab_sel), .count_src(count_src), .chip_reset(chip_reset),
    .stop_disabled(stop_disabled), .pwr_ctl(pwr_ctl), .ctrl_value(ctrl_value));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic complete_run;
    if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr_ctrl(input logic b);
    ctrl_wr = '{1'b1, {b, seed[6:0]}};
    seed = xs(seed);
    cyc(1);
    check("ctrl_value", ctrl_value, ctrl_wr.data);
    ctrl_wr.wr = 0;
  endtask : wr_ctrl
  task automatic to_reset(input int lim);
    n = 0;
    count_src = 1;
    while (seen_rst !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
    count_src = 0;
  endtask : to_reset
  task automatic do_reset;
    reset = 1;
    cyc(2);
    reset = 0;
  endtask : do_reset
  task automatic stop_wake(input int held);
    stop_instruction = 1;
    exp_q.push_back(4'hF);
    cyc(1);
    stop_instruction = 0;
    if (held > 0) begin
      count_src = 1;
      cyc(held);
      count_src = 0;
    end
    wake_irq = 1;
    exp_q.push_back(4'h9);
    cyc(1);
    wake_irq = 0;
  endtask : stop_wake
  // ****************************************
  // Monitor, watchdog and sequence
  // ****************************************
  always @(posedge clk) begin
    if (reset) seen_rst <= 0;
    else if (chip_reset === 1'b1) seen_rst <= 1;
    if (tests_run > 0 && pwr_ctl !== last_pwr)
      check("pwr_ctl", pwr_ctl, exp_q.size() ? exp_q.pop_front() : 4'hx);
    last_pwr <= pwr_ctl;
  end
  initial begin
    #(80000 * 50);
    n_fail++;
    complete_run();
  end
  initial begin
    cyc(5);
    reset = 0;
    check("stop_disabled", stop_disabled, 0);
    wr_ctrl(1);
    count_src = 1;
    cyc(200);
    count_src = 0;
    wr_ctrl(1);
    to_reset(400);
    check("direct_span", n inside {[256:260]}, 1);
    do_reset();
    wr_ctrl(0);
    to_reset(66000);
    check("cascade_span", n inside {[65536:65545]}, 1);
    check("service_max", n >= wdt_pkg::SERVICE_MAX_US, 1);
    do_reset();
    wr_ctrl(1);
    stop_wake(100);
    to_reset(600);
    check("stab_span", n inside {[256:260]}, 1);
    exp_q.push_back(4'h0);
    do_reset();
    wr_ctrl(0);
    stop_wake(0);
    cyc(2);
    count_src = 1;
    cyc(511);
    check("stab_hold", pwr_ctl, 4'h9);
    exp_q.push_back(4'h0);
    cyc(1);
    count_src = 0;
    cyc(3);
    check("stab_done", exp_q.size(), 0);
    stab_sel = 1;
    stop_wake(0);
    exp_q.push_back(4'h0);
    cyc(3);
    check("skip_done", exp_q.size(), 0);
    stab_sel = 0;
    {stop_disable_wr, stop_disable_data} = 2'b11;
    cyc(1);
    stop_disable_data = 0;
    cyc(1);
    stop_disable_wr = 0;
    stop_instruction = 1;
    cyc(1);
    stop_instruction = 0;
    cyc(2);
    check("disabled_stop", {stop_disabled, pwr_ctl}, 5'h10);
    do_reset();
    check("stop_disabled", stop_disabled, 0);
    complete_run();
  end
endmodule : wdt_stop_bench
bind wdt_stop wdt_stop_properties chk (.clk(clk), .reset(reset), .ctrl_wr(ctrl_wr),
  .stop_disable_wr(stop_disable_wr), .stop_disable_data(stop_disable_data),
  .stop_instruction(stop_instruction), .wake_irq(wake_irq), .stab_sel(stab_sel),
  .count_src(count_src), .chip_reset(chip_reset), .stop_disabled(stop_disabled),
  .pwr_ctl(pwr_ctl), .ctrl_value(ctrl_value));
